// file: rtl/rsse_exec.sv
// Execution unit for rotate-through-carry, literal-minus-work and sleep.
// Assumes an AHB-Lite master on SYS_CLK, a data memory whose read data
// follows FILE_OUT.addr in the same cycle, and an asynchronous wake pin.
//
// Behaviour
// - Left rotate: carry into bit0, bit7 out
// - Left rotate destination: 0 work, 1 file
// - Right rotate: carry into bit7, bit0 out
// - Right rotate destination: 0 work, 1 file
// - Sleep clears power-down, sets timeout flag
// - Sleep clears watchdog counter and prescaler
// - Sleep halts oscillator; no execution until wake
// - Work becomes literal minus work, 8-bit
// - Carry, nibble carry: one when work not greater
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps

module rsse_exec (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    output rsse_pkg::rsse_file_t FILE_OUT,
    input wire logic [7:0] FILE_RDATA,
    output logic WATCHDOG_CLEAR,
    output logic OSC_STOP,
    input wire logic WAKE
);
    import rsse_pkg::*;

    // ***************************************************************
    // Bus slave
    // ***************************************************************
    logic dph_q, dph_d;
    logic wr_q, wr_d;
    logic rd_done_q, rd_done_d;
    logic [7:0] adr_q, adr_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic exec_q, exec_d;
    logic [7:0] work_q, work_d;
    logic [5:0] st_q, st_d;
    rsse_instr_t instr_q, instr_d;
    logic fwe_q, fwe_d;
    logic [7:0] fwd_q, fwd_d;
    logic watchdog_clr_q, watchdog_clr_d;
    logic [2:0] wake_s_q, wake_s_d;
    logic ready;
    logic wr_done;

    // Any data phase waits while an instruction executes; reads wait one
    assign ready = !dph_q || (!exec_q && (wr_q || rd_done_q));
    assign wr_done = dph_q && wr_q && ready;
    assign HREADYOUT = ready;
    assign HRESP = HRESP_OKAY;
    assign HRDATA = hrdata_q;

    // Read mux over the mapped words; unmapped reads return zero
    function automatic logic [31:0] read_word(input logic [7:0] a,
                                               input logic [7:0] w,
                                               input logic [5:0] s);
        logic [31:0] v;
        v = 32'h0;
        if (a == OFS_WORK) begin
            v = {24'h0, w};
        end else if (a == OFS_STATUS) begin
            v = {26'h0, s};
        end else if (a == OFS_INSTR) begin
            v = {20'h0, INSTR_W'(instr_q)};
        end
        return v;
    endfunction

    // Address phase capture and data phase sequencing
    always_comb begin
        dph_d = dph_q;
        wr_d = wr_q;
        adr_d = adr_q;
        rd_done_d = rd_done_q;
        hrdata_d = hrdata_q;
        if (dph_q && !wr_q && !rd_done_q && !exec_q) begin
            hrdata_d = read_word(adr_q, work_q, st_q);
            rd_done_d = 1'b1;
        end
        if (ready && HREADY) begin
            dph_d = HSEL && (HTRANS == HTRANS_NONSEQ);
            wr_d = HWRITE;
            adr_d = HADDR[7:0];
            rd_done_d = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            dph_q <= 1'b0;
            wr_q <= 1'b0;
            adr_q <= 8'h00;
            rd_done_q <= 1'b0;
            hrdata_q <= 32'h0;
        end else begin
            dph_q <= dph_d;
            wr_q <= wr_d;
            adr_q <= adr_d;
            rd_done_q <= rd_done_d;
            hrdata_q <= hrdata_d;
        end
    end

    // ***************************************************************
    // Wake pin synchroniser
    // ***************************************************************
    always_comb begin
        wake_s_d = {wake_s_q[1:0], WAKE};
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            wake_s_q <= 3'h0;
        end else begin
            wake_s_q <= wake_s_d;
        end
    end

    // ***************************************************************
    // Execution
    // ***************************************************************
    logic [7:0] diff;
    logic [7:0] rot;
    logic rot_c;

    assign diff = 8'(instr_q.operand - work_q);

    // Instruction issue, rotate, subtract and sleep effects
    always_comb begin
        exec_d = 1'b0;
        instr_d = instr_q;
        work_d = work_q;
        st_d = st_q;
        fwe_d = 1'b0;
        fwd_d = fwd_q;
        watchdog_clr_d = 1'b0;
        rot = FILE_RDATA;
        rot_c = st_q[ST_CARRY];
        // Wake counts once the second and third stages agree high
        if (wake_s_q[1] && wake_s_q[2]) begin
            st_d[ST_ASLEEP] = 1'b0;
        end
        if (wr_done && adr_q == OFS_WORK) begin
            work_d = HWDATA[7:0];
        end
        if (wr_done && adr_q == OFS_STATUS) begin
            st_d = (st_q & ~ST_SW_MASK) | (HWDATA[5:0] & ST_SW_MASK);
        end
        // Instructions are refused while asleep
        if (wr_done && adr_q == OFS_INSTR &&
            !st_q[ST_ASLEEP]) begin
            instr_d = rsse_instr_t'(HWDATA[INSTR_W-1:0]);
            exec_d = 1'b1;
        end
        if (exec_q) begin
            case (instr_q.op)
                OP_ROT_LEFT: begin
                    rot = {FILE_RDATA[6:0], st_q[ST_CARRY]};
                    rot_c = FILE_RDATA[7];
                end
                OP_ROT_RIGHT: begin
                    rot = {st_q[ST_CARRY], FILE_RDATA[7:1]};
                    rot_c = FILE_RDATA[0];
                end
                default: begin
                    rot = FILE_RDATA;
                end
            endcase
            case (instr_q.op)
                OP_ROT_LEFT, OP_ROT_RIGHT: begin
                    // Single cycle; zero flag untouched
                    st_d[ST_CARRY] = rot_c;
                    if (instr_q.dest) begin
                        fwe_d = 1'b1;
                        fwd_d = rot;
                    end else begin
                        work_d = rot;
                    end
                end
                OP_LIT_MINUS_W: begin
                    work_d = diff;
                    st_d[ST_CARRY] = work_q <= instr_q.operand;
                    st_d[ST_NIBBLE] =
                        work_q[3:0] <= instr_q.operand[3:0];
                    st_d[ST_ZERO] = diff == 8'h00;
                end
                OP_SLEEP: begin
                    st_d[ST_PDOWN] = 1'b0;
                    st_d[ST_TOUT] = 1'b1;
                    watchdog_clr_d = 1'b1;
                    st_d[ST_ASLEEP] = 1'b1;
                end
                default: begin
                    work_d = work_q;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            exec_q <= 1'b0;
            instr_q <= rsse_instr_t'(12'h000);
            work_q <= WORK_RST;
            st_q <= STATUS_RST;
            fwe_q <= 1'b0;
            fwd_q <= 8'h00;
            watchdog_clr_q <= 1'b0;
        end else begin
            exec_q <= exec_d;
            instr_q <= instr_d;
            work_q <= work_d;
            st_q <= st_d;
            fwe_q <= fwe_d;
            fwd_q <= fwd_d;
            watchdog_clr_q <= watchdog_clr_d;
        end
    end

    // Outputs straight from flip-flops
    assign FILE_OUT = '{we: fwe_q, addr: instr_q.operand[6:0], wdata: fwd_q};
    assign WATCHDOG_CLEAR = watchdog_clr_q;
    assign OSC_STOP = st_q[ST_ASLEEP];

    // ***************************************************************
    // Assertions
    // ***************************************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    logic is_rl, is_rr, is_sub, is_slp;
    assign is_rl = exec_q && instr_q.op == OP_ROT_LEFT;
    assign is_rr = exec_q && instr_q.op == OP_ROT_RIGHT;
    assign is_sub = exec_q && instr_q.op == OP_LIT_MINUS_W;
    assign is_slp = exec_q && instr_q.op == OP_SLEEP;

    a_rotl_value: assert property (is_rl |=>
        fwe_q ? fwd_q == {$past(FILE_RDATA[6:0]), $past(st_q[ST_CARRY])}
              : work_q == {$past(FILE_RDATA[6:0]), $past(st_q[ST_CARRY])})
        else $error("left rotate result wrong");
    a_rotl_dest: assert property (is_rl |=>
        fwe_q == $past(instr_q.dest) &&
        st_q[ST_CARRY] == $past(FILE_RDATA[7]))
        else $error("left rotate destination or carry wrong");
    a_rotr_value: assert property (is_rr |=>
        st_q[ST_CARRY] == $past(FILE_RDATA[0]) &&
        (fwe_q ? fwd_q[7] : work_q[7]) == $past(st_q[ST_CARRY]))
        else $error("right rotate result wrong");
    a_rotr_dest: assert property (is_rr && !instr_q.dest |=>
        !fwe_q && work_q[6:0] == $past(FILE_RDATA[7:1]))
        else $error("right rotate to work wrong");
    a_sleep_flags: assert property (is_slp |=>
        !st_q[ST_PDOWN] && st_q[ST_TOUT])
        else $error("sleep flags wrong");
    a_sleep_watchdog: assert property (is_slp |=>
        WATCHDOG_CLEAR ##1 !WATCHDOG_CLEAR)
        else $error("watchdog clear pulse wrong");
    a_sleep_halt: assert property (OSC_STOP |-> !exec_q)
        else $error("executed while asleep");
    a_sub_value: assert property (is_sub |=>
        work_q == 8'($past(instr_q.operand) - $past(work_q)))
        else $error("literal minus work wrong");
    a_sub_carry: assert property (is_sub |=>
        st_q[ST_CARRY] == ($past(work_q) <= $past(instr_q.operand)) &&
        st_q[ST_NIBBLE] ==
            ($past(work_q[3:0]) <= $past(instr_q.operand[3:0])))
        else $error("subtract carry wrong");
    a_zero_flag: assert property ((is_rl || is_rr) |=>
        $stable(st_q[ST_ZERO]))
        else $error("rotate changed zero flag");
    a_exec_single: assert property (exec_q |=> !exec_q)
        else $error("execution longer than one cycle");

    c_rot_file: cover property (is_rl && instr_q.dest);
    c_sub_borrow: cover property (is_sub && work_q > instr_q.operand);
    c_sleep_wake: cover property (is_slp ##1 OSC_STOP ##[1:300] !OSC_STOP);

endmodule

// file: rtl/rsse_pkg.sv
// Package for the rotate, subtract-from-literal and sleep execution block.
// Assumes a single 32-bit AHB-Lite master and an external 128-entry
// data memory with combinational read.
package rsse_pkg;

    // ***************************************************************
    // Register map, byte addresses
    // ***************************************************************
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_WORK = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;

    // ***************************************************************
    // Status register fields and reset value
    // ***************************************************************
    localparam int ST_CARRY = 0;
    localparam int ST_NIBBLE = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_PDOWN = 3;
    localparam int ST_TOUT = 4;
    localparam int ST_ASLEEP = 5;
    localparam logic [5:0] ST_SW_MASK = 6'h07;
    localparam logic [5:0] STATUS_RST = 6'h18;
    localparam logic [7:0] WORK_RST = 8'h00;

    // ***************************************************************
    // Instruction word layout and operations
    // ***************************************************************
    typedef enum logic [2:0] {
        OP_NOP,
        OP_ROT_LEFT,
        OP_ROT_RIGHT,
        OP_LIT_MINUS_W,
        OP_SLEEP
    } rsse_op_t;

    typedef struct packed {
        rsse_op_t op;
        logic dest;
        logic [7:0] operand;
    } rsse_instr_t;

    localparam int INSTR_W = 12;

    // Data memory request, all fields from flip-flops
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] wdata;
    } rsse_file_t;

    // AHB constants
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

endpackage

// file: test/rsse_tb.sv
// Self-checking bench for the rotate, literal-minus-work and sleep unit.
// Assumes rsse_pkg and rsse_exec; the bench plays bus master and memory.
`timescale 1ns/1ps

module testbench;
    import rsse_pkg::*;

    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic wake = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic watchdog_clear;
    logic osc_stop;
    logic [7:0] file_rdata;
    rsse_file_t file_out;
    logic [7:0] mem [0:127];
    int num_errors = 0;
    int samples_checked = 0;
    int clear_pulses = 0;

    // Clock, 8 ns period
    always #4 sys_clk = ~sys_clk;

    // Data memory: combinational read, write on the pulse
    assign file_rdata = mem[file_out.addr];
    always @(posedge sys_clk) begin
        if (file_out.we === 1'b1) begin
            mem[file_out.addr] <= file_out.wdata;
        end
        if (watchdog_clear === 1'b1) begin
            clear_pulses <= clear_pulses + 1;
        end
    end

    rsse_exec dut_u (
        .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp), .FILE_OUT(file_out), .FILE_RDATA(file_rdata),
        .WATCHDOG_CLEAR(watchdog_clear), .OSC_STOP(osc_stop),
        .WAKE(wake)
    );

    // ***************************************************************
    // Bus and compare helpers
    // ***************************************************************
    task stop_test;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Sample ready and read data settled before the edge that takes them
    task wait_ready(output logic [31:0] d);
        logic r;
        int n;
        r = 1'b0;
        n = 0;
        d = 32'h0;
        while (r !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            r = hreadyout;
            d = hrdata;
            @(posedge sys_clk);
            n++;
        end
        if (r !== 1'b1) begin
            num_errors++;
            stop_test();
        end
    endtask

    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {24'h0, a};
        wait_ready(rd);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready(rd);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        ahb(1'b1, a, d, v);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        ahb(1'b0, a, 32'h0, v);
        chk(v, e);
    endtask

    // Issue one instruction; the memory pulse lands two cycles later
    task issue(input logic [2:0] op, input logic dst, input logic [7:0] opd);
        wr(OFS_INSTR, {20'h0, op, dst, opd});
        repeat (3) @(posedge sys_clk);
    endtask

    // ***************************************************************
    // Scenarios
    // ***************************************************************
    task t_reset;
        rdc(OFS_STATUS, {26'h0, STATUS_RST});
        chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
        rdc(OFS_WORK, {24'h0, WORK_RST});
        wr(8'h0c, 32'hff);
        rdc(8'h0c, 32'h0);
    endtask

    // Both directions, both destinations, both carry values
    task t_rotate;
        logic [7:0] v;
        logic [7:0] r;
        logic c;
        logic cn;
        logic left;
        logic d;
        logic [6:0] a;
        for (int i = 0; i < 8; i++) begin
            left = i[0];
            d = i[1];
            c = i[2];
            v = 8'he6 ^ {i[2:0], 5'h0};
            a = d ? 7'h7f : 7'h05;
            mem[a] = v;
            wr(OFS_WORK, 32'h5a);
            wr(OFS_STATUS, {29'h0, 1'b1, 1'b0, c});
            issue(left ? 3'h1 : 3'h2, d, {1'b0, a});
            r = left ? {v[6:0], c} : {c, v[7:1]};
            cn = left ? v[7] : v[0];
            chk(32'(mem[a]), 32'(d ? r : v));
            rdc(OFS_WORK, d ? 32'h5a : {24'h0, r});
            rdc(OFS_STATUS, {26'h0, 3'h3, 2'h2, cn});
        end
    endtask

    // Pairs of work and literal around the borrow boundaries
    task t_subtract;
        logic [7:0] w;
        logic [7:0] k;
        logic [7:0] r;
        logic [5:0] s;
        logic [15:0] tbl [0:4];
        tbl = '{16'h0100, 16'h0505, 16'h0f10, 16'h00ff, 16'hff00};
        for (int i = 0; i < 5; i++) begin
            w = tbl[i][15:8];
            k = tbl[i][7:0];
            r = k - w;
            wr(OFS_WORK, {24'h0, w});
            issue(3'h3, 1'b0, k);
            rdc(OFS_WORK, {24'h0, r});
            s = {3'h3, r == 8'h0, w[3:0] <= k[3:0], w <= k};
            rdc(OFS_STATUS, {26'h0, s});
        end
    endtask

    // Sleep, a dropped instruction while asleep, then wake
    task t_sleep;
        int n;
        wr(OFS_STATUS, 32'h0);
        wr(OFS_WORK, 32'h33);
        n = clear_pulses;
        issue(3'h4, 1'b0, 8'h00);
        chk(32'(clear_pulses - n), 32'h1);
        chk({31'h0, osc_stop}, 32'h1);
        rdc(OFS_STATUS, 32'h30);
        mem[5] = 8'h81;
        issue(3'h1, 1'b0, 8'h05);
        rdc(OFS_WORK, 32'h33);
        wake <= 1'b1;
        n = 0;
        while (osc_stop !== 1'b0 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        wake <= 1'b0;
        chk({31'h0, osc_stop}, 32'h0);
        rdc(OFS_STATUS, 32'h10);
    endtask

    // ***************************************************************
    // Main sequence and watchdog
    // ***************************************************************
    initial begin
        foreach (mem[i]) begin
            mem[i] = 8'h00;
        end
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_rotate();
        t_subtract();
        t_sleep();
        stop_test();
    end

    // Cuts a hang short well beyond the expected run length
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        stop_test();
    end
endmodule
